// ### hw/cftf_pkg.sv
package cftf_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int TAPS = 32;
  localparam int SAMP_W = 16;
  localparam int COEF_W = 16;
  localparam int CHAIN_W = 36;
  localparam int RES_W = 24;
  localparam int FIFO_DEPTH = 8;
  localparam int ADDR_W = 8;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_DATA_IN = 8'h08;
  localparam logic [7:0] REG_RESULT = 8'h0c;
  localparam logic [7:0] REG_COEF_BASE = 8'h80;

  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  localparam int CTRL_CWID_LSB = 0;
  localparam int CTRL_SHIFT_LSB = 2;
  localparam int CTRL_CONT_BIT = 4;
  localparam int CTRL_IOBUS_BIT = 5;
  localparam int CTRL_SWAP_BIT = 8;
  localparam logic [1:0] CTRL_CWID_RST = 2'h3;
  localparam logic [1:0] CTRL_SHIFT_RST = 2'h0;

  // ----------------------------------------------------------------
  // status fields
  // ----------------------------------------------------------------
  localparam int STAT_BANK_BIT = 0;
  localparam int STAT_SWAPP_BIT = 1;
  localparam int STAT_SPEND_BIT = 2;
  localparam int STAT_BUSY_BIT = 3;
  localparam int STAT_RAVAIL_BIT = 4;

  // ----------------------------------------------------------------
  // output field positions
  // ----------------------------------------------------------------
  localparam int FIELD_LSB_0 = 7;
  localparam int FIELD_LSB_1 = 11;
  localparam int FIELD_LSB_2 = 15;
  localparam int FIELD_LSB_3 = 20;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ = 40000;
  localparam int RATE_MAX_KSPS = 10000;
  localparam int RATE_MIN_KSPS = 2500;
  localparam int CYC_PER_NIBBLE = CLK_KHZ / RATE_MAX_KSPS;
  localparam int CYC_WIDEST = CLK_KHZ / RATE_MIN_KSPS;

  typedef enum logic {CFTF_IDLE, CFTF_CALC} cftf_state_t;

endpackage

// ### hw/cftf_strm_if.sv
`timescale 1ns/1ps
interface cftf_strm_if #(parameter int WIDTH = 24);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface

// ### hw/cftf_fifo.sv
`timescale 1ns/1ps
module cftf_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  cftf_strm_if.snk wr,
  cftf_strm_if.src rd
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [PW-1:0] wptr_reg, wptr_next, rptr_reg, rptr_next;
  logic [PW:0] cnt_reg, cnt_next;
  logic push, pop;

  assign wr.ready = (cnt_reg != (PW+1)'(DEPTH));
  assign rd.valid = (cnt_reg != '0);
  assign rd.data = mem_reg[rptr_reg];
  assign push = wr.valid && wr.ready;
  assign pop = rd.valid && rd.ready;

  always_comb begin
    mem_next = mem_reg;
    wptr_next = wptr_reg;
    rptr_next = rptr_reg;
    cnt_next = cnt_reg;
    if (push) begin
      mem_next[wptr_reg] = wr.data;
      wptr_next = (wptr_reg == PW'(DEPTH - 1)) ? '0 : wptr_reg + 1'b1;
    end
    if (pop) begin
      rptr_next = (rptr_reg == PW'(DEPTH - 1)) ? '0 : rptr_reg + 1'b1;
    end
    if (push && !pop) begin
      cnt_next = cnt_reg + 1'b1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
      wptr_reg <= '0;
      rptr_reg <= '0;
      cnt_reg <= '0;
    end else begin
      mem_reg <= mem_next;
      wptr_reg <= wptr_next;
      rptr_reg <= rptr_next;
      cnt_reg <= cnt_next;
    end
  end
endmodule

// ### hw/cftf_top.sv
`timescale 1ns/1ps
module cftf_top
  import cftf_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [SAMP_W-1:0] samp_data,
  input wire logic samp_valid,
  output logic samp_ready,
  input wire logic [RES_W-1:0] casc_in,
  output logic [RES_W-1:0] res_data,
  output logic res_valid,
  input wire logic res_ready,
  output logic bank_active
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic signed [COEF_W-1:0] coef_fmt(logic [COEF_W-1:0] c,
                                                       logic [1:0] sel);
    case (sel)
      2'h0: coef_fmt = COEF_W'($signed(c[3:0]));
      2'h1: coef_fmt = COEF_W'($signed(c[7:0]));
      2'h2: coef_fmt = COEF_W'($signed(c[11:0]));
      default: coef_fmt = $signed(c);
    endcase
  endfunction

  function automatic logic [4:0] period_m1(logic [1:0] sel);
    period_m1 = 5'(CYC_PER_NIBBLE * (int'(sel) + 1) - 1);
  endfunction

  function automatic logic [RES_W-1:0] round_field(logic signed [CHAIN_W-1:0] y,
                                                  logic [1:0] sel);
    logic signed [CHAIN_W+8:0] ext;
    logic signed [CHAIN_W+8:0] sh;
    int lsb;
    ext = (CHAIN_W+9)'(y);
    case (sel)
      2'h0: lsb = FIELD_LSB_0;
      2'h1: lsb = FIELD_LSB_1;
      2'h2: lsb = FIELD_LSB_2;
      default: lsb = FIELD_LSB_3;
    endcase
    sh = ext >>> (lsb - 1);
    round_field = sh[RES_W:1] + {{(RES_W-1){1'b0}}, sh[0]};
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  cftf_state_t state_reg, state_next;
  logic [4:0] cnt_reg, cnt_next;
  logic [1:0] cwid_reg, cwid_next, shift_reg, shift_next;
  logic cont_reg, cont_next, iobus_reg, iobus_next;
  logic active_reg, active_next, swapp_reg, swapp_next;
  logic [COEF_W-1:0] coef_reg [2][TAPS];
  logic [COEF_W-1:0] coef_next [2][TAPS];
  logic signed [CHAIN_W-1:0] chain_reg [1:TAPS-1];
  logic signed [CHAIN_W-1:0] chain_next [1:TAPS-1];
  logic [RES_W-1:0] casc_reg [TAPS];
  logic [RES_W-1:0] casc_next [TAPS];
  logic [SAMP_W-1:0] xpend_reg, xpend_next;
  logic xvld_reg, xvld_next;
  logic [RES_W-1:0] result_reg, result_next;
  logic samp_ready_next;
  logic [RES_W-1:0] res_data_next;
  logic res_valid_next;
  logic [31:0] rdata_next;

  logic start, push, bank_use, pop_port, pop_bus;
  logic signed [CHAIN_W-1:0] prod [TAPS];
  logic signed [CHAIN_W-1:0] chain_out;
  logic [4:0] coef_idx;

  cftf_strm_if #(.WIDTH(RES_W)) fifo_in ();
  cftf_strm_if #(.WIDTH(RES_W)) fifo_out ();

  cftf_fifo #(.WIDTH(RES_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .wr(fifo_in),
    .rd(fifo_out)
  );

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  assign push = (state_reg == CFTF_CALC) && (cnt_reg == '0) && fifo_in.ready;
  assign start = xvld_reg && ((state_reg == CFTF_IDLE) || push);
  assign bank_use = active_reg ^ (swapp_reg | cont_reg);
  assign fifo_in.valid = push;
  assign fifo_in.data = result_reg;
  assign pop_port = !iobus_reg && fifo_out.valid && (!res_valid || res_ready);
  assign pop_bus = iobus_reg && reg_rd && (reg_addr == REG_RESULT) && fifo_out.valid;
  assign fifo_out.ready = pop_port || pop_bus;
  assign coef_idx = reg_addr[6:2];

  // ----------------------------------------------------------------
  // multipliers and delay-and-add chain
  // ----------------------------------------------------------------
  always_comb begin
    for (int k = 0; k < TAPS; k++) begin
      prod[k] = CHAIN_W'($signed(xpend_reg) * coef_fmt(coef_reg[bank_use][k], cwid_reg));
    end
    chain_out = prod[0] + chain_reg[1];
  end

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    active_next = active_reg;
    chain_next = chain_reg;
    casc_next = casc_reg;
    result_next = result_reg;
    case (state_reg)
      CFTF_CALC: begin
        if (push) begin
          state_next = CFTF_IDLE;
        end else if (cnt_reg != '0) begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      default: begin
        state_next = CFTF_IDLE;
      end
    endcase
    if (start) begin
      state_next = CFTF_CALC;
      cnt_next = period_m1(cwid_reg);
      active_next = bank_use;
      for (int k = 1; k < TAPS - 1; k++) begin
        chain_next[k] = chain_reg[k+1] + prod[k];
      end
      chain_next[TAPS-1] = prod[TAPS-1];
      casc_next[0] = casc_in;
      for (int k = 1; k < TAPS; k++) begin
        casc_next[k] = casc_reg[k-1];
      end
      result_next = round_field(chain_out, shift_reg) + casc_reg[TAPS-1];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= CFTF_IDLE;
      cnt_reg <= '0;
      active_reg <= 1'b0;
      for (int k = 1; k < TAPS; k++) begin
        chain_reg[k] <= '0;
      end
      for (int k = 0; k < TAPS; k++) begin
        casc_reg[k] <= '0;
      end
      result_reg <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      active_reg <= active_next;
      chain_reg <= chain_next;
      casc_reg <= casc_next;
      result_reg <= result_next;
    end
  end

  // ----------------------------------------------------------------
  // registers, sample entry and result exit
  // ----------------------------------------------------------------
  always_comb begin
    cwid_next = cwid_reg;
    shift_next = shift_reg;
    cont_next = cont_reg;
    iobus_next = iobus_reg;
    coef_next = coef_reg;
    xpend_next = xpend_reg;
    xvld_next = xvld_reg && !start;
    swapp_next = swapp_reg && !start;
    rdata_next = '0;
    if (reg_wr && reg_addr == REG_CTRL) begin
      cwid_next = reg_wdata[CTRL_CWID_LSB +: 2];
      shift_next = reg_wdata[CTRL_SHIFT_LSB +: 2];
      cont_next = reg_wdata[CTRL_CONT_BIT];
      iobus_next = reg_wdata[CTRL_IOBUS_BIT];
      if (reg_wdata[CTRL_SWAP_BIT]) begin
        swapp_next = 1'b1;
      end
    end
    if (reg_wr && reg_addr >= REG_COEF_BASE) begin
      coef_next[~active_reg][coef_idx] = reg_wdata[COEF_W-1:0];
    end
    if (iobus_reg && reg_wr && reg_addr == REG_DATA_IN) begin
      xpend_next = reg_wdata[SAMP_W-1:0];
      xvld_next = 1'b1;
    end else if (!iobus_reg && samp_valid && samp_ready) begin
      xpend_next = samp_data;
      xvld_next = 1'b1;
    end
    samp_ready_next = !iobus_next && !xvld_next;
    res_valid_next = res_valid && !res_ready;
    res_data_next = res_data;
    if (pop_port) begin
      res_valid_next = 1'b1;
      res_data_next = fifo_out.data;
    end
    if (reg_rd) begin
      if (reg_addr == REG_CTRL) begin
        rdata_next[CTRL_CWID_LSB +: 2] = cwid_reg;
        rdata_next[CTRL_SHIFT_LSB +: 2] = shift_reg;
        rdata_next[CTRL_CONT_BIT] = cont_reg;
        rdata_next[CTRL_IOBUS_BIT] = iobus_reg;
      end else if (reg_addr == REG_STATUS) begin
        rdata_next[STAT_BANK_BIT] = active_reg;
        rdata_next[STAT_SWAPP_BIT] = swapp_reg;
        rdata_next[STAT_SPEND_BIT] = xvld_reg;
        rdata_next[STAT_BUSY_BIT] = (state_reg == CFTF_CALC);
        rdata_next[STAT_RAVAIL_BIT] = fifo_out.valid;
      end else if (reg_addr == REG_RESULT && pop_bus) begin
        rdata_next[RES_W-1:0] = fifo_out.data;
      end else if (reg_addr >= REG_COEF_BASE) begin
        rdata_next[COEF_W-1:0] = coef_reg[~active_reg][coef_idx];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cwid_reg <= CTRL_CWID_RST;
      shift_reg <= CTRL_SHIFT_RST;
      cont_reg <= 1'b0;
      iobus_reg <= 1'b0;
      swapp_reg <= 1'b0;
      for (int b = 0; b < 2; b++) begin
        for (int k = 0; k < TAPS; k++) begin
          coef_reg[b][k] <= '0;
        end
      end
      xpend_reg <= '0;
      xvld_reg <= 1'b0;
      samp_ready <= 1'b0;
      res_valid <= 1'b0;
      res_data <= '0;
      reg_rdata <= '0;
      bank_active <= 1'b0;
    end else begin
      cwid_reg <= cwid_next;
      shift_reg <= shift_next;
      cont_reg <= cont_next;
      iobus_reg <= iobus_next;
      swapp_reg <= swapp_next;
      coef_reg <= coef_next;
      xpend_reg <= xpend_next;
      xvld_reg <= xvld_next;
      samp_ready <= samp_ready_next;
      res_valid <= res_valid_next;
      res_data <= res_data_next;
      reg_rdata <= rdata_next;
      bank_active <= active_next;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  period_w16_a: assert property ((start && cwid_reg == 2'h3)
                                 |-> ##15 (cnt_reg == 5'h1) ##1 (cnt_reg == '0))
    else $error("widest period not 16 cycles");
  period_w4_a: assert property ((start && cwid_reg == 2'h0)
                                |-> ##3 (cnt_reg == 5'h1) ##1 (cnt_reg == '0))
    else $error("narrowest period not 4 cycles");
  bank_swap_a: assert property ((start && swapp_reg) |=> (active_reg != $past(active_reg)))
    else $error("requested exchange not applied");
  bank_cont_a: assert property ((start && cont_reg) |=> (active_reg != $past(active_reg)))
    else $error("continuous exchange missed");
  bank_hold_a: assert property (!start |=> $stable(active_reg))
    else $error("bank changed inside a computation");
  bank_read_a: assert property ((reg_rd && reg_addr == REG_STATUS)
                                |=> (reg_rdata[STAT_BANK_BIT] == $past(active_reg)))
    else $error("status bank bit wrong");
  port_mode_a: assert property (iobus_reg |-> !samp_ready)
    else $error("sample port open in bus mode");
  chain_top_a: assert property (start |=> (chain_reg[TAPS-1] == $past(prod[TAPS-1])))
    else $error("chain end stage wrong");
  casc_shift_a: assert property (start |=> (casc_reg[0] == $past(casc_in)))
    else $error("cascade input not captured");

  swap_cov: cover property (start && swapp_reg);
  cont_cov: cover property ((start && cont_reg) ##[1:16] (start && cont_reg));
  full_cov: cover property ((state_reg == CFTF_CALC) && cnt_reg == '0 && !fifo_in.ready);
  bus_res_cov: cover property (pop_bus);
endmodule

// ### tb/cftf_far_model.sv
`timescale 1ns/1ps
// ----
// sample source and result sink
// ----
module cftf_far_model
  import cftf_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic stall,
  output logic [SAMP_W-1:0] samp_data,
  output logic samp_valid,
  input wire logic samp_ready,
  input wire logic [RES_W-1:0] res_data,
  input wire logic res_valid,
  output logic res_ready
);
  logic [SAMP_W-1:0] src [0:63];
  logic [RES_W-1:0] got [0:63];
  int src_n = 0;
  int idx;
  int nx;
  int n_got;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      samp_valid <= 1'b0;
      samp_data <= '0;
      res_ready <= 1'b0;
      idx <= 0;
      n_got <= 0;
    end else begin
      nx = idx + int'(samp_valid && samp_ready);
      idx <= nx;
      if (nx < src_n) begin
        samp_valid <= 1'b1;
        samp_data <= src[nx];
      end else begin
        samp_valid <= 1'b0;
        samp_data <= ~samp_data;
      end
      res_ready <= !stall;
      if (res_valid && res_ready) begin
        got[n_got] <= res_data;
        n_got <= n_got + 1;
      end
    end
  end
endmodule

// ### tb/cftf_tb.sv
`timescale 1ns/1ps
module tb
  import cftf_pkg::*;
;
  localparam logic [RES_W-1:0] CASC = 24'h000155;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [SAMP_W-1:0] samp_data;
  logic samp_valid;
  logic samp_ready;
  logic [RES_W-1:0] casc_in = CASC;
  logic [RES_W-1:0] res_data;
  logic res_valid;
  logic res_ready;
  logic bank_active;
  logic stall = 1'b1;
  int errors = 0;
  int tests_run = 0;
  longint part [0:31];
  int nst = 0;
  logic signed [15:0] cf [0:31];
  logic [23:0] exq [0:63];
  logic [31:0] d;
  logic [15:0] v;
  logic b;
  int q;
  int g = 1;
  always #12.5 clk_sys = ~clk_sys;
  cftf_top dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .samp_data(samp_data), .samp_valid(samp_valid), .samp_ready(samp_ready),
    .casc_in(casc_in), .res_data(res_data), .res_valid(res_valid),
    .res_ready(res_ready), .bank_active(bank_active));
  cftf_far_model far_u (.clk_sys(clk_sys), .rst_n(rst_n), .stall(stall),
    .samp_data(samp_data), .samp_valid(samp_valid), .samp_ready(samp_ready),
    .res_data(res_data), .res_valid(res_valid), .res_ready(res_ready));
  // ----
  // bus access and checking
  // ----
  task automatic wr(input logic [7:0] a, input logic [31:0] dw);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= dw;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] dr);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 dr = reg_rdata;
  endtask
  task automatic chk(input string nm, input logic [35:0] seen, input logic [35:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wait_res;
    logic [31:0] s;
    for (int t = 0; t < 200; t++) begin
      rd(REG_STATUS, s);
      if (s[STAT_RAVAIL_BIT] === 1'b1) return;
    end
    errors++;
    wrap_up();
  endtask
  // ----
  // reference: delay-and-add chain with cascade line
  // ----
  function automatic logic [23:0] step(input logic signed [15:0] x, input int w, input int s);
    longint y;
    logic signed [15:0] t;
    int lsb;
    int sh;
    sh = 12 - 4 * w;
    lsb = s == 0 ? FIELD_LSB_0 : s == 1 ? FIELD_LSB_1 : s == 2 ? FIELD_LSB_2 : FIELD_LSB_3;
    for (int k = 0; k < TAPS; k++) begin
      t = cf[k] <<< sh;
      part[k] += longint'(g) * longint'(t >>> sh) * longint'(x);
    end
    y = part[0];
    for (int k = 0; k < TAPS - 1; k++) part[k] = part[k + 1];
    part[TAPS - 1] = 0;
    y = (y >>> lsb) + ((y >>> (lsb - 1)) & 1);
    step = y[23:0] + (nst >= TAPS ? CASC : 24'h0);
    nst++;
  endfunction
  // ----
  // main sequence
  // ----
  initial begin
    for (int k = 0; k < TAPS; k++) part[k] = 0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(REG_CTRL, d);
    chk("ctrl reset", d, 36'h3);
    rd(REG_STATUS, d);
    chk("status reset", d, 36'h0);
    wr(8'h40, 32'hffffffff);
    rd(8'h40, d);
    chk("unmapped", d, 36'h0);
    for (int k = 0; k < TAPS; k++) begin
      cf[k] = 16'(k * 300 - 4000);
      wr(8'(REG_COEF_BASE + 4 * k), {16'h0, cf[k]});
    end
    rd(8'(REG_COEF_BASE + 20), d);
    chk("coef back", d[15:0], {20'h0, cf[5]});
    wr(REG_CTRL, 32'h103);
    wr(REG_DATA_IN, 32'h1234);
    rd(REG_CTRL, d);
    chk("ctrl swap", d, 36'h3);
    rd(REG_STATUS, d);
    chk("swap pending", d, 36'h2);
    chk("bank held", bank_active, 36'h0);
    far_u.src[0] = 16'h0;
    for (int i = 1; i < 41; i++) far_u.src[i] = 16'(i * 1234 - 20000);
    for (int i = 0; i < 41; i++) exq[i] = step(far_u.src[i], 3, 0);
    far_u.src_n = 41;
    q = 0;
    for (int t = 0; t < 3000 && q < 100; t++) begin
      @(posedge clk_sys);
      #1 q = samp_ready === 1'b0 ? q + 1 : 0;
    end
    if (q < 100) begin
      errors++;
      wrap_up();
    end
    chk("none taken", far_u.n_got, 36'h0);
    chk("res held", res_valid, 36'h1);
    rd(REG_RESULT, d);
    chk("port result", d, 36'h0);
    rd(REG_STATUS, d);
    chk("full bank1", {d[STAT_RAVAIL_BIT], d[STAT_BANK_BIT]}, 36'h3);
    @(posedge clk_sys);
    stall <= 1'b0;
    for (int t = 0; t < 3000 && far_u.n_got < 41; t++) @(posedge clk_sys);
    chk("count", far_u.n_got, 36'd41);
    for (int i = 0; i < 41; i++)
      chk("stream", far_u.got[i], 36'(exq[i]));
    for (int i = 0; i < 4; i++) begin
      wr(REG_CTRL, 32'(32'h20 | (i << 2) | i));
      v = 16'(16'h8001 + i * 16'h1357);
      wr(REG_DATA_IN, {16'h0, v});
      #1;
      chk("bus ready", samp_ready, 36'h0);
      wait_res();
      rd(REG_RESULT, d);
      chk("bus result", d, 36'(step(v, i, i)));
    end
    wr(REG_CTRL, 32'h33);
    b = 1'b1;
    for (int j = 0; j < 2; j++) begin
      wr(REG_DATA_IN, 32'h4321);
      wait_res();
      rd(REG_RESULT, d);
      // bank 0 holds zeros, bank 1 the loaded set; first start uses bank 0
      g = j;
      chk("cont result", d, 36'(step(16'h4321, 3, 0)));
      b = ~b;
      chk("cont bank", bank_active, 36'(b));
    end
    wrap_up();
  end
endmodule
